// *** rtl/config_word_reset_control.v ***
// Configuration word decode, reset holding timers, watchdog and sleep.
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "config_word_defines.vh"

// Functional notes
// - Watchdog cannot be stopped at run time.
// - Watchdog counts ticks of its own oscillator.
// - In crystal modes, start-up timer holds reset until oscillator stable.
// - Power-up delay only after power-on reset.
// - Sleep ends on reset, watchdog or interrupt.
// - Programmed bit reads zero; unused bit 7 reads one.
// - Configuration word sits at address 2007h.
// - Configuration space reachable only in programming mode.
// - Word bit 2 enables the watchdog.
// - Two bits select one of four oscillators.
module config_word_reset_control
#(
    parameter [21:0] POWER_UP_DELAY_TIMER_CYCLES = `POWER_UP_DELAY_TIMER_CYCLES
)
(
    // Clock and power-on reset.
    input  wire        clk,
    input  wire        rst_b,
    // APB slave.
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Device pins and events.
    input  wire        extReset_b,
    input  wire        brownOutDetect,
    input  wire        progMode,
    input  wire        wdtOscTick,
    input  wire        irqPending,
    // Decoded configuration and reset state.
    output reg         resetHold,
    output reg         sleeping,
    output reg         watchdogOn,
    output reg         powerUpTimerOn,
    output reg         brownOutOn,
    output reg  [1:0]  oscMode,
    output reg  [1:0]  protectField,
    output reg         crystalMode
);

    // Sequencer states.
    localparam [2:0] ST_POWER_UP_DELAY_TIMER  = 3'h0;
    localparam [2:0] ST_OST   = 3'h1;
    localparam [2:0] ST_RUN   = 3'h2;
    localparam [2:0] ST_SLEEP = 3'h3;
    localparam [2:0] ST_HOLD  = 3'h4;

    reg  [2:0]  state;        // Current sequencer state.
    reg  [21:0] pwrtCount;    // Power-up delay counter.
    reg  [11:0] ostCount;     // Oscillator start-up counter.
    reg  [15:0] wdtCount;     // Watchdog tick counter.
    reg         tickSeen;     // Previous level of the watchdog tick.
    reg         wdtFlag;      // Sticky watchdog timeout flag.
    reg  [13:0] cfgAddr;      // Program space address for config access.
    reg  [13:0] cfgRead;      // Registered config space read value.
    wire [13:0] cfgWord;      // Stored configuration word.

    // True when an address lies in the test/configuration space.
    function inCfgSpace;
        input [13:0] a;
        begin
            inCfgSpace = (a >= `CFG_SPACE_LO) && (a <= `CFG_SPACE_HI);
        end
    endfunction

    // Bus phases.
    wire access   = psel && penable;
    wire finish   = access && pready;
    wire wrFinish = finish && pwrite;
    wire isData   = (paddr == `REG_CFG_DATA);
    wire isMapped = (paddr == `REG_CONTROL) || (paddr == `REG_STATUS) ||
                    (paddr == `REG_CFG_ADDR) || isData;
    // Data port use outside programming mode is refused.
    wire refused  = !isMapped || (isData && !progMode);

    // Only the word at its fixed address is writable by the programmer.
    wire cfgWrite = wrFinish && isData && progMode &&
                    (cfgAddr == `CFG_WORD_ADDR);

    // Software events.
    wire sleepReq = wrFinish && (paddr == `REG_CONTROL) &&
                    pwdata[`CTRL_SLEEP];
    wire kick     = wrFinish && (paddr == `REG_CONTROL) &&
                    pwdata[`CTRL_KICK];
    wire flagClr  = wrFinish && (paddr == `REG_STATUS) &&
                    pwdata[`STAT_WDT_FLAG];

    // Watchdog timing runs only from its own oscillator ticks.
    wire tickEdge   = wdtOscTick && !tickSeen;
    wire wdtEnabled = cfgWord[`CFG_WDT_EN];
    wire wdtTimeout = wdtEnabled && tickEdge &&
                      (wdtCount == `WDT_TICKS - 16'h0001);

    // Decoded configuration fields.
    wire borEn   = cfgWord[`CFG_BOR_EN];
    wire pwrtEn  = !cfgWord[`CFG_POWER_UP_DELAY_TIMER_EN_B] || borEn;
    wire xtalSel = (cfgWord[`CFG_OSC_HI:`CFG_OSC_LO] != `OSC_RC);

    // The configuration word store.
    config_word_store store
    (
        .clk       (clk),
        .rst_b     (rst_b),
        .writeEn   (cfgWrite),
        .writeData (pwdata[13:0]),
        .word      (cfgWord)
    );

    // Config space read: the stored word, blank elsewhere in the space.
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cfgRead <= `CFG_BLANK_READ;
        end
        else if (cfgAddr == `CFG_WORD_ADDR)
        begin
            cfgRead <= cfgWord;
        end
        else
        begin
            cfgRead <= `CFG_BLANK_READ;
        end
    end

    // APB slave: one wait state, then the transfer completes.
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
            cfgAddr <= 14'h0000;
        end
        else if (finish)
        begin
            // Completion edge: writes land here and the answer drops.
            pready  <= 1'b0;
            pslverr <= 1'b0;
            if (pwrite && (paddr == `REG_CFG_ADDR))
            begin
                cfgAddr <= pwdata[13:0];
            end
        end
        else if (access)
        begin
            // First access edge: prepare the answer.
            pready  <= 1'b1;
            pslverr <= refused;
            prdata  <= 32'h00000000;
            if (!pwrite && !refused)
            begin
                case (paddr)
                    `REG_STATUS:
                    begin
                        prdata <= {24'h000000, oscMode, progMode,
                                   powerUpTimerOn, watchdogOn, wdtFlag,
                                   sleeping, resetHold};
                    end
                    `REG_CFG_ADDR:
                    begin
                        prdata <= {18'h00000, cfgAddr};
                    end
                    `REG_CFG_DATA:
                    begin
                        // Outside the config space nothing is answered.
                        if (inCfgSpace(cfgAddr))
                        begin
                            prdata <= {18'h00000, cfgRead};
                        end
                    end
                    default:
                    begin
                        prdata <= 32'h00000000;
                    end
                endcase
            end
        end
    end

    // Watchdog counter; nothing software does can stop it.
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tickSeen <= 1'b0;
            wdtCount <= 16'h0000;
        end
        else
        begin
            tickSeen <= wdtOscTick;
            if (!wdtEnabled || kick || wdtTimeout || resetHold)
            begin
                wdtCount <= 16'h0000;
            end
            else if (tickEdge)
            begin
                wdtCount <= wdtCount + 16'h0001;
            end
        end
    end

    // Sticky timeout flag; a new timeout wins over a clear.
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wdtFlag <= 1'b0;
        end
        else if (wdtTimeout)
        begin
            wdtFlag <= 1'b1;
        end
        else if (flagClr)
        begin
            wdtFlag <= 1'b0;
        end
    end

    // Reset and sleep sequencer.
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state     <= ST_POWER_UP_DELAY_TIMER;
            pwrtCount <= 22'h000000;
            ostCount  <= 12'h000;
        end
        else if (!extReset_b || (borEn && brownOutDetect))
        begin
            // External or brown-out reset: hold, no power-up delay.
            state    <= ST_HOLD;
            ostCount <= 12'h000;
        end
        else
        begin
            case (state)
                ST_POWER_UP_DELAY_TIMER:
                begin
                    // Only the power-on path passes through here.
                    if (!pwrtEn || (pwrtCount == POWER_UP_DELAY_TIMER_CYCLES - 22'h1))
                    begin
                        state <= ST_OST;
                    end
                    else
                    begin
                        pwrtCount <= pwrtCount + 22'h000001;
                    end
                end
                ST_OST:
                begin
                    // Crystal modes wait for the oscillator to settle.
                    if (!xtalSel || (ostCount == `OST_CYCLES - 12'h1))
                    begin
                        state <= ST_RUN;
                    end
                    else
                    begin
                        ostCount <= ostCount + 12'h001;
                    end
                end
                ST_RUN:
                begin
                    if (wdtTimeout)
                    begin
                        // Watchdog reset while running.
                        state    <= ST_OST;
                        ostCount <= 12'h000;
                    end
                    else if (sleepReq)
                    begin
                        state <= ST_SLEEP;
                    end
                end
                ST_SLEEP:
                begin
                    // Wake-up on watchdog or interrupt.
                    if (wdtTimeout || irqPending)
                    begin
                        state    <= ST_OST;
                        ostCount <= 12'h000;
                    end
                end
                ST_HOLD:
                begin
                    // Released reset restarts through the start-up timer.
                    state <= ST_OST;
                end
                default:
                begin
                    state <= ST_HOLD;
                end
            endcase
        end
    end

    // Registered outputs decoded from the word and the sequencer.
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            resetHold      <= 1'b1;
            sleeping       <= 1'b0;
            watchdogOn     <= 1'b1;
            powerUpTimerOn <= 1'b1;
            brownOutOn     <= 1'b1;
            oscMode        <= `OSC_RC;
            protectField   <= 2'h3;
            crystalMode    <= 1'b0;
        end
        else
        begin
            resetHold      <= (state == ST_POWER_UP_DELAY_TIMER) || (state == ST_OST) ||
                              (state == ST_HOLD);
            sleeping       <= (state == ST_SLEEP);
            watchdogOn     <= wdtEnabled;
            powerUpTimerOn <= pwrtEn;
            brownOutOn     <= borEn;
            oscMode        <= cfgWord[`CFG_OSC_HI:`CFG_OSC_LO];
            protectField   <= cfgWord[`CFG_PROT_HI:`CFG_PROT_LO];
            crystalMode    <= xtalSel;
        end
    end

endmodule

// *** rtl/config_word_defines.vh ***
// Constants shared by the configuration word and reset control design.
`ifndef CONFIG_WORD_DEFINES_VH
`define CONFIG_WORD_DEFINES_VH

// APB register byte offsets.
`define REG_CONTROL      12'h000
`define REG_STATUS       12'h004
`define REG_CFG_ADDR     12'h008
`define REG_CFG_DATA     12'h00c

// Program space addresses of the configuration area.
`define CFG_SPACE_LO     14'h2000
`define CFG_SPACE_HI     14'h3fff
`define CFG_WORD_ADDR    14'h2007

// Configuration word layout.
`define CFG_OSC_LO       0
`define CFG_OSC_HI       1
`define CFG_WDT_EN       2
`define CFG_POWER_UP_DELAY_TIMER_EN_B    3
`define CFG_PROT_LO      4
`define CFG_PROT_HI      5
`define CFG_BOR_EN       6
`define CFG_UNUSED_BIT   7
`define CFG_RESET_WORD   14'h3fff
`define CFG_BLANK_READ   14'h3fff

// Oscillator select encodings.
`define OSC_LOW_POWER    2'h0
`define OSC_STANDARD     2'h1
`define OSC_HIGH_SPEED   2'h2
`define OSC_RC           2'h3

// Control register fields.
`define CTRL_SLEEP       0
`define CTRL_KICK        1

// Status register fields.
`define STAT_RESET_HOLD  0
`define STAT_SLEEPING    1
`define STAT_WDT_FLAG    2
`define STAT_WDT_ON      3
`define STAT_POWER_UP_DELAY_TIMER_ON     4
`define STAT_PROG_MODE   5
`define STAT_OSC_LO      6
`define STAT_OSC_HI      7

// Timing: clock rate and delays.
`define CLK_FREQ_KHZ     50000
`define POWER_UP_DELAY_TIMER_TIME_MS     72
// Power-up delay in clocks, sized to the 22-bit delay counter.
`define POWER_UP_DELAY_TIMER_CYCLES      22'd3600000
`define OST_CYCLES       12'h400
`define WDT_TICKS        16'h0100

`endif

// *** rtl/config_word_store.v ***
// Storage cell for the non-volatile configuration word.
`timescale 1ns/10ps
`include "config_word_defines.vh"

module config_word_store
(
    // Clock and reset.
    input  wire        clk,
    input  wire        rst_b,
    // Write side.
    input  wire        writeEn,
    input  wire [13:0] writeData,
    // Stored word, straight from the register.
    output reg  [13:0] word
);

    // The word powers up unprogrammed; bit 7 is unimplemented and reads 1.
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            word <= `CFG_RESET_WORD;
        end
        else if (writeEn)
        begin
            word <= writeData | (14'h0001 << `CFG_UNUSED_BIT);
        end
    end

endmodule

// *** testbench/config_word_reset_control_checker.sv ***
// Port checks for the configuration word and reset control.
`timescale 1ns/10ps
`include "config_word_defines.vh"
module config_word_reset_control_checker
(
    // Clock, reset and bus.
    input wire        clk,
    input wire        rst_b,
    input wire        psel,
    input wire        penable,
    input wire        pready,
    input wire        pslverr,
    input wire [11:0] paddr,
    // Pins and decoded state.
    input wire        extReset_b,
    input wire        progMode,
    input wire        irqPending,
    input wire        resetHold,
    input wire        sleeping,
    input wire        watchdogOn,
    input wire        powerUpTimerOn,
    input wire        brownOutOn,
    input wire [1:0]  oscMode,
    input wire        crystalMode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    reg [11:0] holdLen;  // Cycles spent in the present reset hold.
    // Counts hold cycles so the start-up delay can be measured.
    always @(posedge clk or negedge rst_b)
        if (!rst_b)
            holdLen <= 12'h000;
        else if (!resetHold)
            holdLen <= 12'h000;
        else if (holdLen != 12'hfff)
            holdLen <= holdLen + 12'h001;
    // First access cycle, still waiting.
    sequence s_wait;
        psel && penable && !pready;
    endsequence
    // Completion cycle of an access.
    sequence s_done;
        psel && penable && pready;
    endsequence
    a_apb_answer: assert property (s_wait |=> pready)
        else $error("pready late after first access cycle");
    a_ready_pulse: assert property (s_done |=> !pready)
        else $error("pready stood longer than one cycle");
    a_cfg_refused: assert property (
        s_done ##0 (paddr == `REG_CFG_DATA && !progMode) |-> pslverr)
        else $error("config space reached outside programming");
    a_osc_decode: assert property (
        crystalMode == (oscMode != `OSC_RC))
        else $error("crystal flag disagrees with oscillator code");
    a_bor_power_up_delay_timer: assert property (brownOutOn |-> powerUpTimerOn)
        else $error("brown-out on without power-up delay");
    a_ext_hold: assert property (!extReset_b |-> ##[1:3] resetHold)
        else $error("external reset did not hold the device");
    a_irq_wake: assert property (sleeping && irqPending |-> ##[1:4] !sleeping)
        else $error("interrupt did not end sleep");
    a_wdt_static: assert property (
        !progMode && !$past(progMode) |-> $stable(watchdogOn))
        else $error("watchdog enable changed at run time");
    a_ost_length: assert property (
        $fell(resetHold) && crystalMode |-> holdLen >= 12'h3fc)
        else $error("reset released before crystal start-up");
endmodule
bind config_word_reset_control config_word_reset_control_checker u_chk
(.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
 .pready(pready), .pslverr(pslverr), .paddr(paddr),
 .extReset_b(extReset_b), .progMode(progMode), .irqPending(irqPending),
 .resetHold(resetHold), .sleeping(sleeping), .watchdogOn(watchdogOn),
 .powerUpTimerOn(powerUpTimerOn), .brownOutOn(brownOutOn),
 .oscMode(oscMode), .crystalMode(crystalMode));

// *** testbench/program_station.sv ***
// Programmer stand-in and watchdog RC oscillator for the bench.
`timescale 1ns/10ps
module program_station
(
    // Clock and requests from the bench.
    input  wire clk,
    input  wire rst_b,
    input  wire wantProg,
    input  wire tickRun,
    // Lines into the block.
    output reg  progMode,
    output reg  wdtOscTick
);
    reg [1:0] divide;  // Sets a tick period of four clocks.
    // Holds the programming level and runs the separate tick source.
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            progMode   <= 1'h0;
            divide     <= 2'h0;
            wdtOscTick <= 1'h0;
        end
        else
        begin
            progMode   <= wantProg;
            divide     <= tickRun ? divide + 2'h1 : 2'h0;
            wdtOscTick <= tickRun & divide[1];
        end
    end
endmodule

// *** testbench/config_word_reset_control_test.sv ***
// Self-checking bench for configuration word and reset control.
`timescale 1ns/10ps
`include "config_word_defines.vh"
module config_word_reset_control_test;
    localparam [21:0] POWER_UP_DELAY_TIMER = 22'd20;  // Shortened power-up delay.
    reg         clk, rst_b, psel, penable, pwrite, err;
    reg  [11:0] paddr;
    reg  [31:0] pwdata, rd;
    reg         extReset_b, brownOutDetect, irqPending, wantProg, tickRun;
    wire [31:0] prdata;
    wire        pready, pslverr, progMode, wdtOscTick, resetHold, sleeping;
    wire        watchdogOn, powerUpTimerOn, brownOutOn, crystalMode;
    wire [1:0]  oscMode, protectField;
    integer     num_errors, tests_run, n, i;
    config_word_reset_control #(.POWER_UP_DELAY_TIMER_CYCLES(POWER_UP_DELAY_TIMER)) u_dut
    (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
     .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
     .pready(pready), .pslverr(pslverr), .extReset_b(extReset_b),
     .brownOutDetect(brownOutDetect), .progMode(progMode),
     .wdtOscTick(wdtOscTick), .irqPending(irqPending),
     .resetHold(resetHold), .sleeping(sleeping), .watchdogOn(watchdogOn),
     .powerUpTimerOn(powerUpTimerOn), .brownOutOn(brownOutOn),
     .oscMode(oscMode), .protectField(protectField),
     .crystalMode(crystalMode));
    program_station u_prog
    (.clk(clk), .rst_b(rst_b), .wantProg(wantProg), .tickRun(tickRun),
     .progMode(progMode), .wdtOscTick(wdtOscTick));
    // Free-running 50 MHz clock.
    always #10 clk = ~clk;
    // Compares one value and counts the outcome.
    task check(input string what, input [31:0] exp, input [31:0] got);
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
        tests_run++;
    endtask
    // One APB transfer; read data and error taken at the ready edge.
    task apb(input reg wr, input reg [11:0] a, input reg [31:0] d);
        integer k;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'h1 && k < 20);
        check("pready", 1, pready);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    // Waits, bounded, for the hold or sleep flag to reach a level.
    task waitFor(input reg useSleep, input reg level, input integer lim);
        n = 0;
        while ((useSleep ? sleeping : resetHold) !== level && n < lim)
        begin
            @(posedge clk);
            n++;
        end
    endtask
    // Prints the counts and the verdict, then stops.
    task results;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Power-up hold, then refused accesses.
    task checkStart;
        waitFor(1'h0, 1'h0, 200);
        check("powerup hold", 1, n >= POWER_UP_DELAY_TIMER && n <= POWER_UP_DELAY_TIMER + 8);
        check("bor forces", 1, powerUpTimerOn);
        apb(1'h0, `REG_CFG_DATA, 32'h0);
        check("cfg refused", 1, err);
        apb(1'h1, 12'h010, 32'h0);
        check("unmapped", 1, err);
        check("bor on", 1, brownOutOn);
        brownOutDetect <= 1'h1;
        repeat (3) @(posedge clk);
        check("bor hold", 1, resetHold);
        brownOutDetect <= 1'h0;
        waitFor(1'h0, 1'h0, 100);
        check("bor no power_up_delay_timer", 1, n <= 6);
    endtask
    // Every oscillator code, enables and config space reads.
    task checkFuses;
        wantProg <= 1'h1;
        apb(1'h1, `REG_CFG_ADDR, 32'h2007);
        for (i = 0; i < 4; i++)
        begin
            apb(1'h1, `REG_CFG_DATA, 32'h3f70 | i);
            apb(1'h0, `REG_CFG_DATA, 32'h0);
            check("word", 32'h3ff0 | i, rd);
            check("osc", i, oscMode);
            check("crystal", i != 3, crystalMode);
            check("wdt off", 0, watchdogOn);
            check("protect", 3, protectField);
        end
        apb(1'h1, `REG_CFG_DATA, 32'h3f3d);
        apb(1'h1, `REG_CFG_ADDR, 32'h2006);
        apb(1'h0, `REG_CFG_DATA, 32'h0);
        check("other cfg", 32'h3fff, rd);
        check("power_up_delay_timer off", 0, powerUpTimerOn);
        check("wdt on", 1, watchdogOn);
        apb(1'h1, `REG_CFG_ADDR, 32'h2007);
        apb(1'h1, `REG_CFG_DATA, 32'h3f05);
        apb(1'h1, `REG_CFG_ADDR, 32'h1fff);
        apb(1'h0, `REG_CFG_DATA, 32'h0);
        check("user space", 0, rd);
        check("power_up_delay_timer on", 1, powerUpTimerOn);
        check("bor off", 0, brownOutOn);
        check("protect", 0, protectField);
        wantProg <= 1'h0;
    endtask
    // Sleep ends on interrupt and on external reset.
    task checkSleep;
        apb(1'h1, `REG_CONTROL, 32'h1);
        waitFor(1'h1, 1'h1, 5);
        check("asleep", 1, sleeping);
        irqPending <= 1'h1;
        waitFor(1'h1, 1'h0, 5);
        check("irq wake", 0, sleeping);
        irqPending <= 1'h0;
        waitFor(1'h0, 1'h0, 1100);
        apb(1'h1, `REG_CONTROL, 32'h1);
        waitFor(1'h1, 1'h1, 5);
        check("asleep again", 1, sleeping);
        extReset_b <= 1'h0;
        repeat (3) @(posedge clk);
        check("reset wake", 0, sleeping);
        check("ext hold", 1, resetHold);
        extReset_b <= 1'h1;
        waitFor(1'h0, 1'h0, 2000);
        check("ost only", 1, n >= 1024 && n <= 1030);
    endtask
    // Watchdog survives writes, wakes from sleep, then resets.
    task checkWatchdog;
        apb(1'h1, `REG_CONTROL, 32'h3);
        check("wdt kept", 1, watchdogOn);
        tickRun <= 1'h1;
        waitFor(1'h1, 1'h1, 5);
        waitFor(1'h1, 1'h0, 1400);
        check("wdt wake", 0, sleeping);
        waitFor(1'h0, 1'h0, 1200);
        waitFor(1'h0, 1'h1, 1400);
        check("wdt reset", 1, resetHold);
        tickRun <= 1'h0;
        apb(1'h0, `REG_STATUS, 32'h0);
        check("timeout flag", 1, rd[2]);
        apb(1'h1, `REG_STATUS, 32'h4);
        apb(1'h0, `REG_STATUS, 32'h0);
        check("flag cleared", 0, rd[2]);
    endtask
    // Main sequence.
    initial
    begin
        {clk, psel, penable, pwrite, rst_b, irqPending} = 6'h00;
        {paddr, pwdata, rd, err, num_errors, tests_run} = 0;
        {extReset_b, brownOutDetect, wantProg, tickRun} = 4'h8;
        repeat (3) @(posedge clk);
        rst_b <= 1'h1;
        checkStart;
        checkFuses;
        checkSleep;
        checkWatchdog;
        results;
    end
    // Cuts a hang short.
    initial
    begin
        #400000;
        num_errors++;
        results;
    end
endmodule
